// file: design/pfs_pkg.sv
package pfs_pkg;

    // ****************************************
    // Buffer geometry
    // ****************************************
    localparam int         FIFO_DEPTH = 66;
    localparam logic [6:0] FIFO_FULL  = 7'h42;
    localparam logic [6:0] PTR_LAST   = 7'h41;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_FIFO    = 8'h00;
    localparam logic [7:0] ADDR_FLAGS   = 8'h04;
    localparam logic [7:0] ADDR_THRESH  = 8'h08;
    localparam logic [7:0] ADDR_OPMODE  = 8'h0c;
    localparam logic [7:0] ADDR_SYNCCFG = 8'h10;
    localparam logic [7:0] ADDR_SYNC_HI = 8'h14;
    localparam logic [7:0] ADDR_SYNC_LO = 8'h18;
    localparam logic [7:0] ADDR_PINMAP  = 8'h1c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int FLG_HAS_DATA = 0;
    localparam int FLG_FULL     = 1;
    localparam int FLG_LEVEL    = 2;
    localparam int FLG_OVERRUN  = 3;
    localparam int FLG_TX_DONE  = 4;
    localparam int FLG_MATCH    = 5;
    localparam int OPM_CONT     = 3;
    localparam int SYNC_EN      = 7;
    localparam int SYNC_LEN_LSB = 3;

    // ****************************************
    // Chip mode codes and reset values
    // ****************************************
    localparam logic [2:0]  MODE_SLEEP   = 3'h0;
    localparam logic [2:0]  MODE_STDBY   = 3'h1;
    localparam logic [2:0]  MODE_FS      = 3'h2;
    localparam logic [2:0]  MODE_TX      = 3'h3;
    localparam logic [2:0]  MODE_RX      = 3'h4;
    localparam logic [3:0]  OPMODE_RST   = 4'h1;
    localparam logic [6:0]  THRESH_RST   = 7'h0f;
    localparam logic [7:0]  SYNCCFG_RST  = 8'h98;
    localparam logic [63:0] SYNCVAL_RST  = 64'h0101010101010101;
    localparam logic [11:0] PINMAP_RST   = 12'h000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Pin source codes: 0 none, 1 ref_clock_out, 2 timeout, 3 rssi, 4 data, 5 dclk,
    // 6 pattern, 7 rx ready, 8 tx ready, 9 low batt, a auto, b mode settled, c lock.
    localparam logic [3:0] SRC_NONE = 4'h0;

    // Status levels from the modem core, all on the chip clock.
    typedef struct packed {
        logic ref_clock_out;
        logic timeout;
        logic rssi;
        logic bit_clk;
        logic receive_ready;
        logic transmit_ready;
        logic low_battery_ind;
        logic auto_sequence_active;
        logic mode_settled;
        logic synth_locked;
    } pfs_side_t;

endpackage

// file: design/pfs_top.sv
`timescale 1ns/1ps
module pfs_top (
    // Clock and reset
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst,
    // AXI4-Lite slave
    input  wire logic                i_awvalid,
    output logic                     o_awready,
    input  wire logic [7:0]          i_awaddr,
    input  wire logic                i_wvalid,
    output logic                     o_wready,
    input  wire logic [31:0]         i_wdata,
    input  wire logic [3:0]          i_wstrb,
    output logic                     o_bvalid,
    input  wire logic                i_bready,
    output logic [1:0]               o_bresp,
    input  wire logic                i_arvalid,
    output logic                     o_arready,
    input  wire logic [7:0]          i_araddr,
    output logic                     o_rvalid,
    input  wire logic                i_rready,
    output logic [31:0]              o_rdata,
    output logic [1:0]               o_rresp,
    // Modem bit stream
    input  wire logic                i_bit_tick,
    input  wire logic                i_demod_bit,
    output logic                     o_mod_bit,
    input  wire pfs_pkg::pfs_side_t  i_side,
    // Status and pins
    output logic                     o_buffer_has_data,
    output logic                     o_buffer_full_ind,
    output logic                     o_buffer_level_ind,
    output logic                     o_frame_tx_done,
    output logic                     o_pattern_match_flag,
    output logic [5:0]               o_gp_pin
);

    // ****************************************
    // State
    // ****************************************
    logic [7:0]  mem [pfs_pkg::FIFO_DEPTH];
    logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, rv_r, rv_nxt;
    logic [7:0]  awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic [3:0]  ws_r, ws_nxt;
    logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
    logic [6:0]  thr_r, thr_nxt;
    logic [3:0]  opm_r, opm_nxt;
    logic [7:0]  scfg_r, scfg_nxt;
    logic [63:0] sval_r, sval_nxt;
    logic [11:0] pmap_r, pmap_nxt;
    logic [6:0]  wp_r, wp_nxt, rp_r, rp_nxt, cnt_r, cnt_nxt;
    logic        ovr_r, ovr_nxt, lvl_r, lvl_nxt, fseen_r, fseen_nxt;
    logic [7:0]  tsr_r, tsr_nxt, rsr_r, rsr_nxt;
    logic [3:0]  tbits_r, tbits_nxt;
    logic [2:0]  rbits_r, rbits_nxt;
    logic        mod_r, mod_nxt, txd_r, txd_nxt, match_r, match_nxt;
    logic [63:0] ssr_r, ssr_nxt;

    logic        do_wr, do_rd, wr_ok, rd_ok, in_rx, in_tx;
    logic        host_push, host_pop, ovr_clr, mode_clr, leave_rx, buf_clr;
    logic        push, pop, push_ok, pop_ok, full;
    logic [7:0]  push_byte, head;
    logic [2:0]  new_mode;
    logic [5:0]  shamt;
    logic [63:0] pat, mask;
    logic [6:0]  errs;
    logic [15:0] src_vec;
    logic [31:0] pmap_wide;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [6:0] popcnt(input logic [63:0] v);
        logic [6:0] c;
        c = 7'h00;
        for (int b = 0; b < 64; b++)
        begin
            c = c + {6'h00, v[b]};
        end
        return c;
    endfunction

    // ****************************************
    // Bus decode
    // ****************************************
    assign o_awready = !aw_r;
    assign o_wready  = !w_r;
    assign o_arready = !rv_r;
    assign do_wr     = aw_r && w_r && !b_r;
    assign do_rd     = i_arvalid && !rv_r;
    assign wr_ok     = awa_r[1:0] == 2'h0 && awa_r <= pfs_pkg::ADDR_PINMAP;
    assign rd_ok     = i_araddr[1:0] == 2'h0 && i_araddr <= pfs_pkg::ADDR_PINMAP;
    assign in_rx     = opm_r[2:0] == pfs_pkg::MODE_RX;
    assign in_tx     = opm_r[2:0] == pfs_pkg::MODE_TX;
    assign new_mode  = wd_r[2:0];
    assign full      = cnt_r == pfs_pkg::FIFO_FULL;
    assign head      = mem[rp_r[6:0]];
    // Both access kinds hit the same entry each time, never a neighbour.
    assign host_push = do_wr && awa_r == pfs_pkg::ADDR_FIFO && ws_r[0] && !in_rx;
    assign host_pop  = do_rd && i_araddr == pfs_pkg::ADDR_FIFO && !in_tx && cnt_r != 7'h00;
    assign ovr_clr   = do_wr && awa_r == pfs_pkg::ADDR_FLAGS && ws_r[0] && wd_r[pfs_pkg::FLG_OVERRUN];
    assign mode_clr  = do_wr && awa_r == pfs_pkg::ADDR_OPMODE && ws_r[0] &&
                       ((new_mode == pfs_pkg::MODE_RX && (opm_r[2:0] == pfs_pkg::MODE_STDBY ||
                         opm_r[2:0] == pfs_pkg::MODE_SLEEP)) ||
                        (in_rx && new_mode == pfs_pkg::MODE_TX) ||
                        (in_tx && new_mode != pfs_pkg::MODE_TX));
    assign leave_rx  = do_wr && awa_r == pfs_pkg::ADDR_OPMODE && ws_r[0] && in_rx && new_mode != pfs_pkg::MODE_RX;
    assign buf_clr   = ovr_clr || mode_clr;
    assign pmap_wide = merge({20'h00000, pmap_r}, wd_r, ws_r);

    always_comb
    begin
        aw_nxt   = aw_r || i_awvalid;
        awa_nxt  = (!aw_r && i_awvalid) ? i_awaddr : awa_r;
        w_nxt    = w_r || i_wvalid;
        wd_nxt   = (!w_r && i_wvalid) ? i_wdata : wd_r;
        ws_nxt   = (!w_r && i_wvalid) ? i_wstrb : ws_r;
        b_nxt    = b_r && !i_bready;
        br_nxt   = br_r;
        rv_nxt   = rv_r && !i_rready;
        rd_nxt   = rd_r;
        rr_nxt   = rr_r;
        thr_nxt  = thr_r;
        opm_nxt  = opm_r;
        scfg_nxt = scfg_r;
        sval_nxt = sval_r;
        pmap_nxt = pmap_r;
        if (do_wr)
        begin
            aw_nxt = 1'b0;
            w_nxt  = 1'b0;
            b_nxt  = 1'b1;
            br_nxt = wr_ok ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
            case (awa_r)
                pfs_pkg::ADDR_THRESH:  thr_nxt  = ws_r[0] ? wd_r[6:0] : thr_r;
                pfs_pkg::ADDR_OPMODE:  opm_nxt  = ws_r[0] ? wd_r[3:0] : opm_r;
                pfs_pkg::ADDR_SYNCCFG: scfg_nxt = ws_r[0] ? wd_r[7:0] : scfg_r;
                pfs_pkg::ADDR_SYNC_HI: sval_nxt[63:32] = merge(sval_r[63:32], wd_r, ws_r);
                pfs_pkg::ADDR_SYNC_LO: sval_nxt[31:0]  = merge(sval_r[31:0], wd_r, ws_r);
                pfs_pkg::ADDR_PINMAP:  pmap_nxt = pmap_wide[11:0];
                default:               thr_nxt  = thr_r;
            endcase
        end
        if (do_rd)
        begin
            rv_nxt = 1'b1;
            rr_nxt = rd_ok ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
            case (i_araddr)
                pfs_pkg::ADDR_FIFO:    rd_nxt = {24'h000000, host_pop ? head : 8'h00};
                // Flags are captured as the read starts, so a read in flight is stale.
                pfs_pkg::ADDR_FLAGS:   rd_nxt = {26'h0000000, match_r, txd_r, ovr_r, lvl_r, full,
                                                 cnt_r != 7'h00};
                pfs_pkg::ADDR_THRESH:  rd_nxt = {25'h0000000, thr_r};
                pfs_pkg::ADDR_OPMODE:  rd_nxt = {28'h0000000, opm_r};
                pfs_pkg::ADDR_SYNCCFG: rd_nxt = {24'h000000, scfg_r};
                pfs_pkg::ADDR_SYNC_HI: rd_nxt = sval_r[63:32];
                pfs_pkg::ADDR_SYNC_LO: rd_nxt = sval_r[31:0];
                pfs_pkg::ADDR_PINMAP:  rd_nxt = {20'h00000, pmap_r};
                default:               rd_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            aw_r   <= 1'b0;
            awa_r  <= 8'h00;
            w_r    <= 1'b0;
            wd_r   <= 32'h00000000;
            ws_r   <= 4'h0;
            b_r    <= 1'b0;
            br_r   <= 2'h0;
            rv_r   <= 1'b0;
            rd_r   <= 32'h00000000;
            rr_r   <= 2'h0;
            thr_r  <= pfs_pkg::THRESH_RST;
            opm_r  <= pfs_pkg::OPMODE_RST;
            scfg_r <= pfs_pkg::SYNCCFG_RST;
            sval_r <= pfs_pkg::SYNCVAL_RST;
            pmap_r <= pfs_pkg::PINMAP_RST;
        end
        else
        begin
            aw_r   <= aw_nxt;
            awa_r  <= awa_nxt;
            w_r    <= w_nxt;
            wd_r   <= wd_nxt;
            ws_r   <= ws_nxt;
            b_r    <= b_nxt;
            br_r   <= br_nxt;
            rv_r   <= rv_nxt;
            rd_r   <= rd_nxt;
            rr_r   <= rr_nxt;
            thr_r  <= thr_nxt;
            opm_r  <= opm_nxt;
            scfg_r <= scfg_nxt;
            sval_r <= sval_nxt;
            pmap_r <= pmap_nxt;
        end
    end

    assign o_bvalid = b_r;
    assign o_bresp  = br_r;
    assign o_rvalid = rv_r;
    assign o_rdata  = rd_r;
    assign o_rresp  = rr_r;

    // ****************************************
    // Buffer, serializer and deserializer
    // ****************************************
    always_comb
    begin
        tsr_nxt   = tsr_r;
        tbits_nxt = tbits_r;
        mod_nxt   = mod_r;
        txd_nxt   = txd_r;
        rsr_nxt   = rsr_r;
        rbits_nxt = in_rx ? rbits_r : 3'h0;
        push      = host_push;
        push_byte = wd_r[7:0];
        pop       = host_pop;
        if (in_tx && i_bit_tick)
        begin
            if (tbits_r != 4'h0)
            begin
                mod_nxt   = tsr_r[7];
                tsr_nxt   = {tsr_r[6:0], 1'b0};
                tbits_nxt = tbits_r - 4'h1;
                txd_nxt   = tbits_r == 4'h1 && cnt_r == 7'h00;
            end
            else if (cnt_r != 7'h00)
            begin
                pop       = 1'b1;
                mod_nxt   = head[7];
                tsr_nxt   = {head[6:0], 1'b0};
                tbits_nxt = 4'h7;
                txd_nxt   = 1'b0;
            end
        end
        if (in_rx && i_bit_tick)
        begin
            rsr_nxt   = {rsr_r[6:0], i_demod_bit};
            rbits_nxt = rbits_r + 3'h1;
            if (rbits_r == 3'h7)
            begin
                push      = 1'b1;
                push_byte = rsr_nxt;
            end
        end
        if (!in_tx)
        begin
            tbits_nxt = 4'h0;
        end
        push_ok = push && !full;
        pop_ok  = pop && cnt_r != 7'h00;
        ovr_nxt = (ovr_r && !ovr_clr) || (push && full);
        wp_nxt  = push_ok ? ((wp_r == pfs_pkg::PTR_LAST) ? 7'h00 : wp_r + 7'h01) : wp_r;
        rp_nxt  = pop_ok ? ((rp_r == pfs_pkg::PTR_LAST) ? 7'h00 : rp_r + 7'h01) : rp_r;
        cnt_nxt = cnt_r + {6'h00, push_ok} - {6'h00, pop_ok};
        lvl_nxt   = lvl_r;
        fseen_nxt = fseen_r;
        if (push_ok || pop_ok)
        begin
            fseen_nxt = (fseen_r || cnt_nxt == pfs_pkg::FIFO_FULL) && cnt_nxt != 7'h00;
            lvl_nxt   = (fseen_r && cnt_nxt != 7'h00) ? lvl_r : (cnt_nxt > thr_r);
        end
        if (buf_clr)
        begin
            wp_nxt    = 7'h00;
            rp_nxt    = 7'h00;
            cnt_nxt   = 7'h00;
            lvl_nxt   = 1'b0;
            fseen_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (push_ok)
        begin
            mem[wp_r] <= push_byte;
        end
        if (i_rst)
        begin
            wp_r    <= 7'h00;
            rp_r    <= 7'h00;
            cnt_r   <= 7'h00;
            ovr_r   <= 1'b0;
            lvl_r   <= 1'b0;
            fseen_r <= 1'b0;
            tsr_r   <= 8'h00;
            tbits_r <= 4'h0;
            mod_r   <= 1'b0;
            txd_r   <= 1'b0;
            rsr_r   <= 8'h00;
            rbits_r <= 3'h0;
        end
        else
        begin
            wp_r    <= wp_nxt;
            rp_r    <= rp_nxt;
            cnt_r   <= cnt_nxt;
            ovr_r   <= ovr_nxt;
            lvl_r   <= lvl_nxt;
            fseen_r <= fseen_nxt;
            tsr_r   <= tsr_nxt;
            tbits_r <= tbits_nxt;
            mod_r   <= mod_nxt;
            txd_r   <= txd_nxt;
            rsr_r   <= rsr_nxt;
            rbits_r <= rbits_nxt;
        end
    end

    assign o_buffer_has_data  = cnt_r != 7'h00;
    assign o_buffer_full_ind  = full;
    assign o_buffer_level_ind = lvl_r;
    assign o_frame_tx_done    = txd_r;
    assign o_mod_bit          = mod_r;

    // ****************************************
    // Pattern detector
    // ****************************************
    // Zero bytes in the pattern are not guarded against; the host keeps them out.
    assign shamt = {3'h7 - scfg_r[pfs_pkg::SYNC_LEN_LSB +: 3], 3'h0};
    assign pat   = sval_r >> shamt;
    assign mask  = {64{1'b1}} >> shamt;

    always_comb
    begin
        ssr_nxt = in_rx ? ssr_r : 64'h0000000000000000;
        if (in_rx && i_bit_tick && scfg_r[pfs_pkg::SYNC_EN])
        begin
            ssr_nxt = {ssr_r[62:0], i_demod_bit};
        end
        errs = popcnt((ssr_nxt ^ pat) & mask);
        // A match in the same cycle as a clear still lands.
        match_nxt = (match_r && !leave_rx && !(cnt_r != 7'h00 && cnt_nxt == 7'h00)) ||
                    (in_rx && i_bit_tick && scfg_r[pfs_pkg::SYNC_EN] &&
                     errs <= {4'h0, scfg_r[2:0]});
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            ssr_r   <= 64'h0000000000000000;
            match_r <= 1'b0;
        end
        else
        begin
            ssr_r   <= ssr_nxt;
            match_r <= match_nxt;
        end
    end

    assign o_pattern_match_flag = match_r;

    // ****************************************
    // Pin multiplexer
    // ****************************************
    assign src_vec = {3'h0, i_side.synth_locked, i_side.mode_settled, i_side.auto_sequence_active,
                      i_side.low_battery_ind, i_side.transmit_ready, i_side.receive_ready, match_r,
                      i_side.bit_clk, in_tx ? mod_r : i_demod_bit, i_side.rssi, i_side.timeout,
                      i_side.ref_clock_out, 1'b0};

    // One table row per mode and mapping code, one nibble per pin from pin 5 down to pin 0.
    function automatic logic [23:0] row(input logic [2:0] m, input logic [1:0] c);
        logic [23:0] r;
        r = 24'h000000;
        case ({m, c})
            {pfs_pkg::MODE_SLEEP, 2'h2}: r = 24'h99a099;
            {pfs_pkg::MODE_SLEEP, 2'h3}: r = 24'hb0000b;
            {pfs_pkg::MODE_STDBY, 2'h0}: r = 24'h100000;
            {pfs_pkg::MODE_STDBY, 2'h2}: r = 24'h99a099;
            {pfs_pkg::MODE_STDBY, 2'h3}: r = 24'hb0000b;
            {pfs_pkg::MODE_FS, 2'h0}:    r = 24'h10000c;
            {pfs_pkg::MODE_FS, 2'h2}:    r = 24'h99a099;
            {pfs_pkg::MODE_FS, 2'h3}:    r = 24'hbc00cb;
            {pfs_pkg::MODE_RX, 2'h0}:    r = 24'h123456;
            {pfs_pkg::MODE_RX, 2'h1}:    r = 24'h377472;
            {pfs_pkg::MODE_RX, 2'h2}:    r = 24'h96a493;
            {pfs_pkg::MODE_RX, 2'h3}:    r = 24'hbc246b;
            {pfs_pkg::MODE_TX, 2'h0}:    r = 24'h18845c;
            {pfs_pkg::MODE_TX, 2'h1}:    r = 24'h188488;
            {pfs_pkg::MODE_TX, 2'h2}:    r = 24'h99a499;
            {pfs_pkg::MODE_TX, 2'h3}:    r = 24'hbc84cb;
            default:                     r = 24'h000000;
        endcase
        return r;
    endfunction

    for (genvar p = 0; p < 6; p++)
    begin : g_pin
        logic [23:0] tab;
        logic [3:0]  sel;
        logic        pin_r;
        assign tab = row(opm_r[2:0], pmap_r[2*p +: 2]);
        assign sel = opm_r[pfs_pkg::OPM_CONT] ? tab[4*p +: 4] : pfs_pkg::SRC_NONE;
        always_ff @(posedge i_ref_clk)
        begin
            if (i_rst)
            begin
                pin_r <= 1'b0;
            end
            else
            begin
                pin_r <= src_vec[sel];
            end
        end
        assign o_gp_pin[p] = pin_r;
    end

endmodule // pfs_top

// file: dv/pfs_checker.sv
`timescale 1ns/1ps
module pfs_checker (
    // Clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    // Watched ports
    input wire logic        i_awvalid,
    input wire logic        i_arvalid,
    input wire logic        i_rready,
    input wire logic        i_bit_tick,
    input wire logic        o_rvalid,
    input wire logic [31:0] o_rdata,
    input wire logic        o_mod_bit,
    input wire logic        o_buffer_has_data,
    input wire logic        o_buffer_full_ind,
    input wire logic        o_buffer_level_ind,
    input wire logic        o_frame_tx_done,
    input wire logic        o_pattern_match_flag,
    input wire logic [5:0]  o_gp_pin
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // Any event that can move a byte into or out of the buffer.
    wire touch = i_bit_tick | i_awvalid | i_arvalid;
    sequence rd_wait;
        o_rvalid && !i_rready;
    endsequence
    full_data_a: assert property (o_buffer_full_ind |-> o_buffer_has_data)
        else $error("full without data");
    reset_quiet_a: assert property ($fell(i_rst) |->
        !o_buffer_has_data && !o_pattern_match_flag && o_gp_pin == 6'h00)
        else $error("outputs not clear after reset");
    level_touch_a: assert property ($changed(o_buffer_level_ind) |->
        $past(touch) || $past(touch, 2) || $past(touch, 3) || $past(touch, 4))
        else $error("level moved without traffic");
    mod_touch_a: assert property ($changed(o_mod_bit) |->
        $past(touch) || $past(touch, 2) || $past(touch, 3))
        else $error("serial bit moved without tick");
    done_rise_a: assert property ($rose(o_frame_tx_done) |->
        !o_buffer_has_data && ($past(i_bit_tick) || $past(i_bit_tick, 2)))
        else $error("frame done at wrong time");
    match_rise_a: assert property ($rose(o_pattern_match_flag) |->
        $past(i_bit_tick) || $past(i_bit_tick, 2))
        else $error("match without bit");
    match_clear_a: assert property ($fell(o_buffer_has_data) && !i_bit_tick && !$past(i_bit_tick)
        |=> !o_pattern_match_flag)
        else $error("match kept on empty buffer");
    read_hold_a: assert property (rd_wait |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
endmodule // pfs_checker

bind pfs_top pfs_checker i_chk (.*);

// file: dv/pfs_modem_model.sv
`timescale 1ns/1ps
module pfs_modem_model (
    // Clock and control
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic [4:0]  i_n,
    input  wire logic [15:0] i_word,
    // Serial side
    input  wire logic        i_mod_bit,
    output logic             o_tick,
    output logic             o_bit,
    output logic             o_busy,
    output logic [15:0]      o_cap
);
    logic [4:0]  n_r  = '0;
    logic [1:0]  ph_r = '0;
    logic [15:0] sh_r = '0;
    initial o_tick = '0;
    initial o_bit = '0;
    initial o_cap = '0;
    assign o_busy = n_r != 5'h0;
    always @(posedge i_clk)
    begin
        o_tick <= 1'h0;
        if (i_go)
        begin
            n_r  <= i_n;
            sh_r <= i_word;
        end
        else if (o_busy)
        begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h3)
            begin
                o_tick <= 1'h1;
                o_bit  <= sh_r[15];
                sh_r   <= sh_r << 1;
                n_r    <= n_r - 5'h1;
                o_cap  <= {o_cap[14:0], i_mod_bit};
            end
        end
        else
            o_bit <= ~o_bit; // Idle line toggles so no stale bit looks valid.
    end
endmodule // pfs_modem_model

// file: dv/test_packet_fifo_sync_detect_pinmux.sv
`timescale 1ns/1ps
module test_packet_fifo_sync_detect_pinmux;
    logic        i_ref_clk = '0, i_rst = '1, i_awvalid = '0, i_wvalid = '0, i_bready = '0, go = '0;
    logic        i_arvalid = '0, i_rready = '0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic        i_bit_tick, i_demod_bit, o_mod_bit, busy, o_buffer_has_data, o_buffer_full_ind;
    logic        o_buffer_level_ind, o_frame_tx_done, o_pattern_match_flag;
    logic [1:0]  o_bresp, o_rresp, rs;
    logic [3:0]  i_wstrb = '1;
    logic [4:0]  nt = '0;
    logic [5:0]  o_gp_pin;
    logic [7:0]  i_awaddr = '0, i_araddr = '0, p;
    logic [15:0] wv = '0, cap;
    logic [31:0] i_wdata = '0, o_rdata, d;
    int          mismatches = 0, n_tests = 0, cyc = 0, k, sd;
    logic [7:0]  q[$];
    pfs_pkg::pfs_side_t i_side = '0;
    always #4 i_ref_clk = ~i_ref_clk;
    pfs_top i_dut (.*);
    pfs_modem_model i_modem (.i_clk(i_ref_clk), .i_go(go), .i_n(nt), .i_word(wv), .i_mod_bit(o_mod_bit),
        .o_tick(i_bit_tick), .o_bit(i_demod_bit), .o_busy(busy), .o_cap(cap));
    function automatic logic [5:0] pins_exp(input pfs_pkg::pfs_side_t s, input logic m);
        return {s.ref_clock_out, s.timeout, s.rssi, 1'h0, s.bit_clk, m};
    endfunction
    task finish_test;
        $display("mismatches %0d comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Handshakes are judged at the falling edge, where they equal what the next rising edge samples.
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic ra, rw, rb;
        {i_awvalid, i_wvalid, i_bready, i_awaddr, i_wdata} <= {3'h7, a, v};
        forever
        begin
            @(negedge i_ref_clk);
            {ra, rw, rb, rs} = {o_awready & i_awvalid, o_wready & i_wvalid, o_bvalid, o_bresp};
            @(posedge i_ref_clk);
            if (ra) i_awvalid <= 1'h0;
            if (rw) i_wvalid <= 1'h0;
            if (rb) break;
        end
        i_bready <= 1'h0;
        @(posedge i_ref_clk);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        logic ra, rv;
        {i_arvalid, i_rready, i_araddr} <= {2'h3, a};
        forever
        begin
            @(negedge i_ref_clk);
            {ra, rv, v, s} = {o_arready & i_arvalid, o_rvalid, o_rdata, o_rresp};
            @(posedge i_ref_clk);
            if (ra) i_arvalid <= 1'h0;
            if (rv) break;
        end
        i_rready <= 1'h0;
        @(posedge i_ref_clk);
    endtask
    task run(input logic [4:0] n, input logic [15:0] w);
        {go, nt, wv} <= {1'h1, n, w};
        @(posedge i_ref_clk);
        go <= 1'h0;
        @(negedge i_ref_clk);
        while (busy) @(negedge i_ref_clk);
    endtask
    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            mismatches++;
            finish_test();
        end
    end
    initial
    begin
        sd = $urandom(32'h3521a498);
        repeat (6) @(posedge i_ref_clk) i_rst <= cyc < 4;
        for (k = 0; k < 66; k++)
        begin
            q.push_back(8'($urandom));
            wr(pfs_pkg::ADDR_FIFO, {24'h0, q[k]});
        end
        wr(pfs_pkg::ADDR_FIFO, 32'h5a);
        rd(pfs_pkg::ADDR_FLAGS, d, rs);
        chk("full_flags", 32'hf, d & 32'hf);
        chk("full_pins", 32'h3, {30'h0, o_buffer_full_ind, o_buffer_has_data});
        for (k = 0; k < 66; k++)
        begin
            rd(pfs_pkg::ADDR_FIFO, d, rs);
            chk("fifo_byte", {24'h0, q[k]}, d);
            rd(pfs_pkg::ADDR_FLAGS, d, rs);
            chk("level_held", {31'h0, k < 65}, 32'(d[pfs_pkg::FLG_LEVEL]));
        end
        rd(8'h20, d, rs);
        chk("unmapped", pfs_pkg::RESP_SLVERR, rs);
        wr(8'h20, 32'h0);
        chk("unmapped_wr", pfs_pkg::RESP_SLVERR, rs);
        wr(pfs_pkg::ADDR_FLAGS, 32'h8);
        chk("w1c_resp", pfs_pkg::RESP_OKAY, rs);
        rd(pfs_pkg::ADDR_FLAGS, d, rs);
        chk("w1c", 32'h0, d & 32'hf);
        for (k = 0; k < 17; k++)
        begin
            wr(pfs_pkg::ADDR_FIFO, $urandom);
            if (k == 15) wr(pfs_pkg::ADDR_THRESH, 32'h20);
            rd(pfs_pkg::ADDR_FLAGS, d, rs);
            chk("level", {31'h0, k > 14 && k < 16}, 32'(d[pfs_pkg::FLG_LEVEL]));
            chk("level_pin", {31'h0, k > 14 && k < 16}, 32'(o_buffer_level_ind));
        end
        for (k = 0; k < 4; k++)
        begin
            wr(pfs_pkg::ADDR_OPMODE, {29'h0, k[0] ? pfs_pkg::MODE_TX : pfs_pkg::MODE_SLEEP});
            rd(pfs_pkg::ADDR_FLAGS, d, rs);
            chk("mode_keep", {31'h0, k < 2}, 32'(d[pfs_pkg::FLG_HAS_DATA]));
        end
        p = 8'($urandom_range(255, 1));
        i_side <= pfs_pkg::pfs_side_t'($urandom);
        wr(pfs_pkg::ADDR_OPMODE, 32'h0c);
        wr(pfs_pkg::ADDR_SYNCCFG, 32'h81);
        wr(pfs_pkg::ADDR_SYNC_HI, {p, 24'h010101});
        run(5'h10, {p ^ 8'h10, 8'($urandom)});
        chk("match", 32'h1, 32'(o_pattern_match_flag));
        chk("pins", 32'(pins_exp(i_side, 1'h1)), 32'(o_gp_pin & 6'h3b));
        @(posedge i_ref_clk);
        rd(pfs_pkg::ADDR_FIFO, d, rs);
        chk("rx_byte", {24'h0, p ^ 8'h10}, d);
        wr(pfs_pkg::ADDR_OPMODE, 32'h09);
        rd(pfs_pkg::ADDR_FLAGS, d, rs);
        chk("leave_rx", 32'h1, d & 32'h21);
        wr(pfs_pkg::ADDR_FLAGS, 32'h8);
        wr(pfs_pkg::ADDR_FIFO, {24'h0, p});
        wr(pfs_pkg::ADDR_OPMODE, {28'h0, 1'h1, pfs_pkg::MODE_TX});
        run(5'h09, 16'h0);
        chk("tx_byte", {24'h0, p}, {24'h0, cap[7:0]});
        chk("tx_pin", {31'h0, p[0]}, 32'(o_gp_pin[2]));
        chk("tx_done", 32'h1, 32'(o_frame_tx_done));
        finish_test();
    end
endmodule // test_packet_fifo_sync_detect_pinmux
